/* src/ivq_pkg.sv */
// Constants, register map and vector codes of the interrupt vector queue unit.
// Assumes one clock domain shared by all internal sources and the host side.
package ivq_pkg;
  localparam int          IVQ_FIFO_DEPTH = 16;
  localparam int          VEC_W          = 32;
  localparam int          NUM_QUEUES     = 10;
  localparam int          NUM_SRC        = 5;
  localparam int          ADDR_W         = 8;
  localparam int          PTR_W          = 8;

  localparam logic [7:0]  OFF_STATUS     = 8'h00;
  localparam logic [7:0]  OFF_MASK       = 8'h04;
  localparam logic [7:0]  OFF_QLEN       = 8'h08;
  localparam logic [7:0]  OFF_LEVEL      = 8'h0c;
  localparam logic [1:0]  BASE_PAGE      = 2'h1;

  localparam logic [9:0]  MASK_RESET     = 10'h3ff;
  localparam logic [7:0]  QLEN_RESET     = 8'h10;

  localparam logic [3:0]  CODE_CFG       = 4'ha;
  localparam logic [3:0]  CODE_SYNC      = 4'hc;
  localparam logic [3:0]  CODE_LOCAL     = 4'hd;
  localparam logic [3:0]  CODE_PORT      = 4'hf;
  localparam logic [3:0]  TAG_DMA        = 4'h2;

  localparam logic [3:0]  Q_CFG          = 4'h8;
  localparam logic [3:0]  Q_PERIPH       = 4'h9;

  localparam int          SRC_CFG        = 0;
  localparam int          SRC_CHAN       = 1;
  localparam int          SRC_SYNC       = 2;
  localparam int          SRC_LOCAL      = 3;
  localparam int          SRC_PORT       = 4;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_BUSY = 1'b1
  } wr_state_t;
endpackage

/* src/ivq_fifo.sv */
// Central vector FIFO with valid/ready on both sides.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ivq_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  input  wire logic [WIDTH-1:0]           in_data_in,
  output logic                            out_valid_out,
  input  wire logic                       out_ready_in,
  output logic [WIDTH-1:0]                out_data_out,
  output logic [$clog2(DEPTH+1)-1:0]      level_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("ivq_fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [LW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [LW-1:0]    next_count;
  logic             push;
  logic             pop;

  always_comb begin
    push         = in_valid_in && (count != LW'(DEPTH));
    pop          = out_ready_in && (count != '0);
    next_wr_ptr  = push ? wr_ptr + PW'(1) : wr_ptr;
    next_rd_ptr  = pop ? rd_ptr + PW'(1) : rd_ptr;
    next_count   = count + LW'(push) - LW'(pop);
    in_ready_out  = (count != LW'(DEPTH));
    out_valid_out = (count != '0);
    out_data_out  = mem[rd_ptr];
    level_out     = count;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; a word is read only after it was written.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule // ivq_fifo
`default_nettype wire

/* src/interrupt_vector_queue_unit.sv */
// Interrupt vector queue unit: formats source vectors, buffers them and
// writes them into ten circular queues in host memory.
// Assumes sources, register port and memory port share mclk_in.
`timescale 1ns/100ps
`default_nettype none
module interrupt_vector_queue_unit
  import ivq_pkg::*;
#(
  parameter int FIFO_DEPTH = IVQ_FIFO_DEPTH
) (
  input  wire logic               mclk_in,
  input  wire logic               rst_in,
  input  wire logic [ADDR_W-1:0]  reg_addr_in,
  input  wire logic [31:0]        reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic [31:0]             reg_rdata_out,
  input  wire logic [NUM_SRC-1:0] src_valid_in,
  output logic [NUM_SRC-1:0]      src_grant_out,
  input  wire logic               cfg_failed_in,
  input  wire logic [2:0]         channel_identifier_in,
  input  wire logic               chan_is_dma_in,
  input  wire logic [18:0]        channel_event_status_in,
  input  wire logic               sync_serial_dir_in,
  input  wire logic               sync_serial_sel_in,
  input  wire logic [2:0]         sync_serial_flags_in,
  input  wire logic [15:0]        sync_serial_control_status_in,
  input  wire logic [15:0]        sync_serial_receive_buffer_in,
  input  wire logic [15:0]        port_data_register_in,
  output logic                    mem_req_out,
  output logic [31:0]             mem_addr_out,
  output logic [VEC_W-1:0]        mem_data_out,
  input  wire logic               mem_ack_in,
  output logic                    irq_out
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256 ||
      (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be a power of two from 2 to 256");
  end

  function automatic logic [3:0] queue_of(input logic [VEC_W-1:0] v);
    if (!v[31]) begin
      queue_of = {1'b0, v[30:28]};
    end else if (v[31:28] == CODE_CFG) begin
      queue_of = Q_CFG;
    end else begin
      queue_of = Q_PERIPH;
    end
  endfunction

  logic [VEC_W-1:0]  push_word;
  logic              push_valid;
  logic              push_ready;
  logic              pop_ready;
  logic              fifo_valid;
  logic [VEC_W-1:0]  fifo_word;
  logic [LW-1:0]     fifo_level;
  logic [NUM_SRC-1:0] next_grant;
  logic [15:0]       sync_low;

  // Vector formatting and source arbitration.
  always_comb begin
    push_valid = |(src_valid_in & src_grant_out);
    push_word  = '0;
    sync_low   = 16'h0000;
    if (sync_serial_sel_in) begin
      sync_low = sync_serial_control_status_in;
    end else if (sync_serial_dir_in) begin
      sync_low = sync_serial_receive_buffer_in;
    end
    if (src_grant_out[SRC_CFG]) begin
      push_word = {CODE_CFG, 26'h0, cfg_failed_in, !cfg_failed_in};
    end else if (src_grant_out[SRC_CHAN] && chan_is_dma_in) begin
      push_word = {1'b0, channel_identifier_in, TAG_DMA, 5'h00,
                   channel_event_status_in[18:16], 16'h0000};
    end else if (src_grant_out[SRC_CHAN]) begin
      push_word = {1'b0, channel_identifier_in, 9'h000,
                   channel_event_status_in};
    end else if (src_grant_out[SRC_SYNC]) begin
      push_word = {CODE_SYNC, 3'h0, sync_serial_dir_in, sync_serial_sel_in,
                   4'h0, sync_serial_flags_in, sync_low};
    end else if (src_grant_out[SRC_LOCAL]) begin
      push_word = {CODE_LOCAL, 28'h0000000};
    end else if (src_grant_out[SRC_PORT]) begin
      push_word = {CODE_PORT, 12'h000, port_data_register_in};
    end
    // A grant lasts one cycle and is never followed at once by another,
    // so the level seen here already counts every accepted vector.
    next_grant = '0;
    if (src_grant_out == '0 && fifo_level < LW'(FIFO_DEPTH)) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (src_valid_in[i]) begin
          next_grant = NUM_SRC'(1) << i;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      src_grant_out <= '0;
    end else begin
      src_grant_out <= next_grant;
    end
  end

  ivq_fifo #(
    .WIDTH (VEC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_word),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop_ready),
    .out_data_out  (fifo_word),
    .level_out     (fifo_level)
  );

  logic [31:0]       base [NUM_QUEUES];
  logic [31:0]       next_base [NUM_QUEUES];
  logic [PTR_W-1:0]  wptr [NUM_QUEUES];
  logic [PTR_W-1:0]  next_wptr [NUM_QUEUES];
  logic [7:0]        qlen;
  logic [NUM_QUEUES-1:0] set_bits;
  wr_state_t         state;
  wr_state_t         next_state;
  logic [3:0]        cur_queue;
  logic [3:0]        next_queue;
  logic              next_req;
  logic [31:0]       next_addr;
  logic [VEC_W-1:0]  next_data;
  logic [PTR_W-1:0]  inc;

  // Host queue writer: one vector in flight, held until the memory acks.
  always_comb begin
    next_state = state;
    next_queue = cur_queue;
    next_req   = mem_req_out;
    next_addr  = mem_addr_out;
    next_data  = mem_data_out;
    set_bits   = '0;
    inc        = '0;
    pop_ready  = (state == WR_IDLE);
    for (int i = 0; i < NUM_QUEUES; i++) begin
      next_wptr[i] = wptr[i];
    end
    case (state)
      WR_IDLE: begin
        if (fifo_valid) begin
          next_state = WR_BUSY;
          next_queue = queue_of(fifo_word);
          next_addr  = base[queue_of(fifo_word)] +
                       {22'h0, wptr[queue_of(fifo_word)], 2'h0};
          next_data  = fifo_word;
          next_req   = 1'b1;
        end
      end
      WR_BUSY: begin
        if (mem_ack_in) begin
          inc        = wptr[cur_queue] + PTR_W'(1);
          next_wptr[cur_queue] = (inc >= qlen) ? '0 : inc;
          set_bits[cur_queue] = 1'b1;
          next_req   = 1'b0;
          next_state = WR_IDLE;
        end
      end
      default: begin
        next_state = WR_IDLE;
        next_req   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state        <= WR_IDLE;
      cur_queue    <= '0;
      mem_req_out  <= 1'b0;
      mem_addr_out <= '0;
      mem_data_out <= '0;
      for (int i = 0; i < NUM_QUEUES; i++) begin
        wptr[i] <= '0;
      end
    end else begin
      state        <= next_state;
      cur_queue    <= next_queue;
      mem_req_out  <= next_req;
      mem_addr_out <= next_addr;
      mem_data_out <= next_data;
      for (int i = 0; i < NUM_QUEUES; i++) begin
        wptr[i] <= next_wptr[i];
      end
    end
  end

  logic [NUM_QUEUES-1:0] global_queue_status;
  logic [NUM_QUEUES-1:0] queue_mask;
  logic [NUM_QUEUES-1:0] next_status;
  logic [NUM_QUEUES-1:0] next_mask;
  logic [NUM_QUEUES-1:0] clr_bits;
  logic [7:0]            next_qlen;
  logic [31:0]           next_rdata;
  logic                  base_hit;
  logic [3:0]            base_idx;

  // Register port; a new vector wins over a clear in the same cycle.
  always_comb begin
    base_idx  = reg_addr_in[5:2];
    base_hit  = (reg_addr_in[7:6] == BASE_PAGE) &&
                (base_idx < 4'(NUM_QUEUES));
    clr_bits  = (reg_wr_in && reg_addr_in == OFF_STATUS) ?
                reg_wdata_in[NUM_QUEUES-1:0] : '0;
    next_status = (global_queue_status & ~clr_bits) | set_bits;
    next_mask = (reg_wr_in && reg_addr_in == OFF_MASK) ?
                reg_wdata_in[NUM_QUEUES-1:0] : queue_mask;
    next_qlen = (reg_wr_in && reg_addr_in == OFF_QLEN) ?
                reg_wdata_in[7:0] : qlen;
    for (int i = 0; i < NUM_QUEUES; i++) begin
      next_base[i] = base[i];
    end
    if (reg_wr_in && base_hit) begin
      next_base[base_idx] = {reg_wdata_in[31:2], 2'h0};
    end
    next_rdata = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == OFF_STATUS) begin
        next_rdata = {22'h0, global_queue_status};
      end else if (reg_addr_in == OFF_MASK) begin
        next_rdata = {22'h0, queue_mask};
      end else if (reg_addr_in == OFF_QLEN) begin
        next_rdata = {24'h0, qlen};
      end else if (reg_addr_in == OFF_LEVEL) begin
        next_rdata = 32'(fifo_level);
      end else if (base_hit) begin
        next_rdata = base[base_idx];
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      global_queue_status <= '0;
      queue_mask    <= MASK_RESET;
      qlen          <= QLEN_RESET;
      reg_rdata_out <= '0;
      irq_out       <= 1'b0;
      for (int i = 0; i < NUM_QUEUES; i++) begin
        base[i] <= '0;
      end
    end else begin
      global_queue_status <= next_status;
      queue_mask    <= next_mask;
      qlen          <= next_qlen;
      reg_rdata_out <= next_rdata;
      irq_out       <= |(global_queue_status & queue_mask);
      for (int i = 0; i < NUM_QUEUES; i++) begin
        base[i] <= next_base[i];
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  irq_level_a: assert property (
    ##1 irq_out == $past(|(global_queue_status & queue_mask)))
    else $error("interrupt line does not follow pending flags");
  status_set_a: assert property (
    (state == WR_BUSY && mem_ack_in) |=> global_queue_status[$past(cur_queue)])
    else $error("queue flag not set after vector write");
  w1c_clear_a: assert property (
    (reg_wr_in && reg_addr_in == OFF_STATUS && reg_wdata_in[0] &&
     !set_bits[0]) |=> !global_queue_status[0])
    else $error("write one did not clear queue flag");
  cfg_word_a: assert property (
    (mem_req_out && mem_data_out[31:28] == CODE_CFG) |->
      (mem_data_out[27:2] == 26'h0 && mem_data_out[1] != mem_data_out[0]))
    else $error("configuration word malformed");
  cfg_route_a: assert property (
    (mem_req_out && mem_data_out[31:28] == CODE_CFG) |-> cur_queue == Q_CFG)
    else $error("configuration word outside its queue");
  chan_route_a: assert property (
    (mem_req_out && !mem_data_out[31]) |->
      cur_queue == {1'b0, mem_data_out[30:28]})
    else $error("channel vector in wrong queue");
  port_word_a: assert property (
    (push_valid && src_grant_out[SRC_PORT]) |->
      push_word[27:16] == 12'h000 && push_word[31:28] == CODE_PORT)
    else $error("port vector malformed");
  full_hold_a: assert property (
    (fifo_level == LW'(FIFO_DEPTH)) |=> src_grant_out == '0)
    else $error("grant issued while FIFO full");
  no_drop_a: assert property (
    push_valid |-> push_ready)
    else $error("vector pushed into full FIFO");

  cfg_write_c: cover property (mem_req_out && mem_ack_in && cur_queue == Q_CFG);
  fifo_full_c: cover property (fifo_level == LW'(FIFO_DEPTH));
  irq_clear_c: cover property (irq_out ##1 !irq_out);
endmodule // interrupt_vector_queue_unit
`default_nettype wire

/* sim/host_mem_model.sv */
// Host memory model: acknowledges vector writes and keeps the last one.
// Assumes the writer holds its request until the cycle after the ack.
`timescale 1ns/100ps
`default_nettype none
module host_mem_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        req_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] data_in,
  input  wire logic        stall_in,
  input  wire logic [1:0]  delay_in,
  output logic             ack_out,
  output logic [31:0]      last_addr_out,
  output logic [31:0]      last_data_out,
  output int               count_out
);
  logic [1:0] wait_cnt;
  // A stalled host never acks, so the vector FIFO can be filled.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out   <= 1'b0;
      wait_cnt  <= 2'h0;
      count_out <= 0;
    end else begin
      ack_out <= 1'b0;
      if (ack_out) begin
        last_addr_out <= addr_in;
        last_data_out <= data_in;
        count_out     <= count_out + 1;
      end else if (req_in && !stall_in) begin
        if (wait_cnt == delay_in) begin
          ack_out  <= 1'b1;
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule // host_mem_model
`default_nettype wire

/* sim/interrupt_vector_queue_unit_tb.sv */
// Testbench: the bench acts as sources and CPU, the model as host memory.
// Assumes one clock; a small FIFO depth keeps the fill test short.
`timescale 1ns/100ps
`default_nettype none
module interrupt_vector_queue_unit_tb;
  import ivq_pkg::*;
  localparam int FD = 4;
  typedef struct packed {
    logic [2:0]  src;
    logic [31:0] arg;
    logic [31:0] vec;
    logic [3:0]  q;
  } row_t;
  row_t rows [9] = '{
    '{3'd0, 32'h0000_0001, 32'ha000_0002, 4'h8},
    '{3'd0, 32'h0000_0000, 32'ha000_0001, 4'h8},
    '{3'd1, 32'h2005_a5c3, 32'h2005_a5c3, 4'h2},
    '{3'd1, 32'hf005_1234, 32'h7205_0000, 4'h7},
    '{3'd2, 32'h0085_beef, 32'hc085_beef, 4'h9},
    '{3'd2, 32'h0102_1234, 32'hc102_edcb, 4'h9},
    '{3'd2, 32'h0001_5555, 32'hc001_0000, 4'h9},
    '{3'd3, 32'h0000_0000, 32'hd000_0000, 4'h9},
    '{3'd4, 32'h0000_abcd, 32'hf000_abcd, 4'h9}};
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic [31:0] arg = 32'h0;
  logic [31:0] got;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [4:0]  src_valid_in = 5'h0;
  logic        stall = 1'b0;
  logic [1:0]  delay = 2'h0;
  logic [31:0] reg_rdata_out, mem_addr_out, mem_data_out, l_addr, l_data;
  logic [4:0]  src_grant_out;
  logic        mem_req_out, mem_ack_in, irq_out;
  int          fails = 0;
  int          comparisons = 0;
  int          count, n0, k;
  int          wp [10] = '{default: 0};
  bit          ok;

  always #25 mclk_in = ~mclk_in;

  interrupt_vector_queue_unit #(.FIFO_DEPTH(FD))
    i_interrupt_vector_queue_unit (
    .mclk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .src_valid_in, .src_grant_out,
    .cfg_failed_in(arg[0]), .channel_identifier_in(arg[30:28]),
    .chan_is_dma_in(arg[31]), .channel_event_status_in(arg[18:0]),
    .sync_serial_dir_in(arg[24]), .sync_serial_sel_in(arg[23]),
    .sync_serial_flags_in(arg[18:16]),
    .sync_serial_control_status_in(arg[15:0]),
    .sync_serial_receive_buffer_in(~arg[15:0]),
    .port_data_register_in(arg[15:0]), .mem_req_out, .mem_addr_out,
    .mem_data_out, .mem_ack_in, .irq_out);

  host_mem_model i_host_mem_model (
    .mclk_in, .rst_in, .req_in(mem_req_out), .addr_in(mem_addr_out),
    .data_in(mem_data_out), .stall_in(stall), .delay_in(delay),
    .ack_out(mem_ack_in), .last_addr_out(l_addr),
    .last_data_out(l_data), .count_out(count));

  task automatic conclude;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic timeout;
    fails++;
    conclude;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic irq_is(input logic b);
    chk({31'h0, irq_out}, {31'h0, b});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    got = reg_rdata_out;
  endtask
  // Valid stays up after a refusal, as a stalled source must keep it.
  task automatic send(input int s);
    ok = 1'b0;
    @(posedge mclk_in);
    src_valid_in[s] <= 1'b1;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(negedge mclk_in);
      ok = src_grant_out[s] === 1'b1;
    end
    if (ok) begin
      @(posedge mclk_in);
      src_valid_in[s] <= 1'b0;
    end
  endtask
  task automatic put(input int s, input logic [31:0] a, v, input int q);
    @(posedge mclk_in);
    arg <= a;
    n0 = count;
    send(s);
    if (!ok) timeout;
    for (int i = 0; i < 40 && count == n0; i++) @(negedge mclk_in);
    if (count == n0) timeout;
    chk(l_addr, 32'h1000 * (q + 1) + 4 * wp[q]);
    chk(l_data, v);
    wp[q] = (wp[q] + 1 >= 2) ? 0 : wp[q] + 1;
  endtask
  task automatic go(input int s, input logic [31:0] a, v, input int q);
    put(s, a, v, q);
    cycles(3);
    irq_is(1'b1);
    rd(OFF_STATUS);
    chk(got, 32'h1 << q);
    wr(OFF_STATUS, 32'h1 << q);
    cycles(3);
    irq_is(1'b0);
  endtask

  initial begin
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    cycles(1);
    irq_is(1'b0);
    rd(OFF_MASK);
    chk(got, 32'h3ff);
    rd(OFF_QLEN);
    chk(got, 32'h10);
    rd(8'h80);
    chk(got, 32'h0);
    wr(OFF_QLEN, 32'h2);
    // Low bits set in each base check that the word alignment is forced.
    for (int q = 0; q < 10; q++) wr(8'h40 + 8'(4 * q), 32'h1000 * (q + 1) + 3);
    foreach (rows[i]) begin
      delay <= 2'(i);
      go(rows[i].src, rows[i].arg, rows[i].vec, rows[i].q);
    end
    for (int c = 0; c < 8; c++)
      go(1, {1'b0, 3'(c), 9'h0, 19'(c + 5)}, {1'b0, 3'(c), 9'h0, 19'(c + 5)}, c);
    wr(OFF_MASK, 32'h1ff);
    put(4, 32'h55aa, 32'hf000_55aa, 9);
    cycles(3);
    irq_is(1'b0);
    put(0, 32'h1, 32'ha000_0002, 8);
    cycles(3);
    irq_is(1'b1);
    rd(OFF_STATUS);
    chk(got, 32'h300);
    wr(OFF_STATUS, 32'h100);
    rd(OFF_STATUS);
    chk(got, 32'h200);
    irq_is(1'b0);
    wr(OFF_MASK, 32'h3ff);
    cycles(3);
    irq_is(1'b1);
    wr(OFF_STATUS, 32'h200);
    stall <= 1'b1;
    n0 = count;
    k = 0;
    ok = 1'b1;
    while (ok && k < 2 * FD + 4) begin
      @(posedge mclk_in);
      arg <= 32'(k);
      send(4);
      if (ok) k++;
    end
    rd(OFF_LEVEL);
    chk(got, 32'(FD));
    chk(32'(k >= FD && k <= FD + 1), 32'h1);
    stall <= 1'b0;
    send(4);
    chk(32'(ok), 32'h1);
    for (int i = 0; i < 400 && count < n0 + k + 1; i++) @(negedge mclk_in);
    chk(32'(count - n0), 32'(k + 1));
    chk(l_data, 32'hf000_0000 | 32'(k));
    rd(OFF_STATUS);
    chk(got, 32'h200);
    wr(OFF_LEVEL, 32'hff);
    rd(OFF_LEVEL);
    chk(got, 32'h0);
    // A reset in mid-run must bring the mask, queue length and status registers back to their reset values.
    wr(OFF_MASK, 32'h0f0);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    cycles(2);
    chk(32'({mem_req_out, src_grant_out, irq_out}), 32'h0);
    @(posedge mclk_in);
    rst_in <= 1'b0;
    cycles(1);
    chk(32'({mem_req_out, src_grant_out, irq_out}), 32'h0);
    rd(OFF_MASK);
    chk(got, 32'h3ff);
    rd(OFF_QLEN);
    chk(got, 32'h10);
    rd(OFF_STATUS);
    chk(got, 32'h0);
    conclude;
  end
endmodule // interrupt_vector_queue_unit_tb
`default_nettype wire
